// File: rtl/sys_clock_out_gate_and_id.sv
// Clock output select, peripheral bus clock gating and part identification
`timescale 1ns/1ps
`include "sys_clock_consts.svh"

module sys_clock_out_gate_and_id #(
    parameter logic [11:0] PART_ID = `PART_ID_VALUE
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Register port
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Clock sources
    input wire logic xtal_one_clk,
    input wire logic xtal_two_clk,
    input wire logic rc_osc_clk,
    input wire logic cpu_clock,
    input wire logic low_power_osc_clock,
    input wire logic time_of_day_source_clk,
    // Clock output pin and timer side effect
    output logic clock_output_pin,
    output logic first_timer_ext_clk_alt,
    // Peripheral bus clock enables and time-of-day count clock
    output logic [7:0] periph_clock_gate_one_en,
    output logic [7:0] periph_clock_gate_two_en,
    output logic [1:0] keyboard_interrupt_bus_en,
    output logic [1:0] programmable_comparator_bus_en,
    output logic delay_block_reg_bus_en,
    output logic time_of_day_bus_en,
    output logic time_of_day_count_clk
);

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    // Reset image of the select register, split into its fields below
    localparam logic [7:0] RST_SEL = `RST_CLOCK_OUTPUT_SELECT;
    sys_clock_pkg::clk_out_sel_type sel_ff;
    logic test_bit_ff;
    logic [7:0] gate_one_ff;
    logic [7:0] gate_two_ff;
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;
    logic wr_sel;
    logic wr_gate_one;
    logic wr_gate_two;

    clk_src_if src ();

    always_comb begin
        wr_sel = 1'b0;
        wr_gate_one = 1'b0;
        wr_gate_two = 1'b0;
        if (reg_addr == `ADDR_CLOCK_OUTPUT_SELECT) begin
            wr_sel = reg_wr;
        end else if (reg_addr == `ADDR_PERIPH_CLOCK_GATE_ONE) begin
            wr_gate_one = reg_wr;
        end else if (reg_addr == `ADDR_PERIPH_CLOCK_GATE_TWO) begin
            wr_gate_two = reg_wr;
        end
    end

    // ------------------------------------------------------------------
    // Clock output select
    // ------------------------------------------------------------------
    // Codes above 110 are kept as written but drive the pin low
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sel_ff <= sys_clock_pkg::clk_out_sel_type'(
                RST_SEL[`SEL_MSB:`SEL_LSB]);
        end else if (wr_sel) begin
            sel_ff <= sys_clock_pkg::clk_out_sel_type'(
                reg_wdata[`SEL_MSB:`SEL_LSB]);
        end
    end

    // Software must keep this at zero; it is stored and forwarded as is
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            test_bit_ff <= RST_SEL[`TEST_BIT];
        end else if (wr_sel) begin
            test_bit_ff <= reg_wdata[`TEST_BIT];
        end
    end

    assign first_timer_ext_clk_alt = test_bit_ff;

    assign src.xtal_one = xtal_one_clk;
    assign src.xtal_two = xtal_two_clk;
    assign src.rc_osc = rc_osc_clk;
    assign src.bus_clock = clock;
    assign src.cpu_clock = cpu_clock;
    assign src.low_power_osc_clock = low_power_osc_clock;
    assign src.sel = sel_ff;

    // Changing the select while sources run may shorten one pulse
    clk_out_mux u_clk_out_mux (
        .src(src.mux)
    );

    assign clock_output_pin = src.mux_out;

    // ------------------------------------------------------------------
    // Peripheral clock gating
    // ------------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            gate_one_ff <= `RST_PERIPH_CLOCK_GATE;
        end else if (wr_gate_one) begin
            gate_one_ff <= reg_wdata;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            gate_two_ff <= `RST_PERIPH_CLOCK_GATE;
        end else if (wr_gate_two) begin
            gate_two_ff <= reg_wdata;
        end
    end

    assign periph_clock_gate_one_en = gate_one_ff;
    assign periph_clock_gate_two_en = gate_two_ff;
    assign keyboard_interrupt_bus_en =
        {2{gate_two_ff[`GATE_TWO_KEYBOARD_BIT]}};
    assign programmable_comparator_bus_en =
        {2{gate_two_ff[`GATE_TWO_COMPARATOR_BIT]}};
    assign delay_block_reg_bus_en =
        gate_two_ff[`GATE_TWO_DELAY_BIT];
    assign time_of_day_bus_en =
        gate_two_ff[`GATE_TWO_TIME_OF_DAY_BIT];
    // Count clock passes straight through so gating saves no time keeping
    assign time_of_day_count_clk = time_of_day_source_clk;

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    // Writes to the id addresses fall through the decode and are dropped
    always_comb begin
        nxt_rdata = 8'h00;
        if (reg_addr == `ADDR_CLOCK_OUTPUT_SELECT) begin
            nxt_rdata = {test_bit_ff, 4'h0, sel_ff};
        end else if (reg_addr == `ADDR_PART_ID_HIGH) begin
            nxt_rdata = {4'h0, PART_ID[11:8]};
        end else if (reg_addr == `ADDR_PART_ID_LOW) begin
            nxt_rdata = PART_ID[7:0];
        end else if (reg_addr == `ADDR_PERIPH_CLOCK_GATE_ONE) begin
            nxt_rdata = gate_one_ff;
        end else if (reg_addr == `ADDR_PERIPH_CLOCK_GATE_TWO) begin
            nxt_rdata = gate_two_ff;
        end
    end

    // Data stands only in the cycle after the read strobe
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rdata_ff <= 8'h00;
        end else if (reg_rd) begin
            rdata_ff <= nxt_rdata;
        end else begin
            rdata_ff <= 8'h00;
        end
    end

    assign reg_rdata = rdata_ff;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    property p_sel_off_low;
        @(posedge clock) disable iff (!rst_n)
        sel_ff == sys_clock_pkg::SEL_OFF |-> !clock_output_pin;
    endproperty
    a_sel_off_low: assert property (p_sel_off_low)
        else $error("clock output not low with select 000");

    property p_sel_write_xtal;
        @(posedge clock) disable iff (!rst_n)
        wr_sel && reg_wdata[2:0] == 3'h1 |=>
            clock_output_pin == xtal_one_clk;
    endproperty
    a_sel_write_xtal: assert property (p_sel_write_xtal)
        else $error("clock output does not follow crystal one");

    property p_stopped_source;
        @(posedge clock) disable iff (!rst_n)
        sel_ff == sys_clock_pkg::SEL_LOW_POWER_OSC && !low_power_osc_clock
            |-> !clock_output_pin;
    endproperty
    a_stopped_source: assert property (p_stopped_source)
        else $error("clock output moves with its source stopped");

    property p_reserved_read;
        @(posedge clock) disable iff (!rst_n)
        reg_rd && reg_addr == `ADDR_CLOCK_OUTPUT_SELECT |=>
            reg_rdata[6:3] == 4'h0 &&
            reg_rdata[7] == first_timer_ext_clk_alt;
    endproperty
    a_reserved_read: assert property (p_reserved_read)
        else $error("reserved select bits read wrong");

    property p_id_high;
        @(posedge clock) disable iff (!rst_n)
        reg_rd && reg_addr == `ADDR_PART_ID_HIGH |=>
            reg_rdata == {4'h0, PART_ID[11:8]};
    endproperty
    a_id_high: assert property (p_id_high)
        else $error("id high register read wrong");

    property p_id_low;
        @(posedge clock) disable iff (!rst_n)
        reg_rd && reg_addr == `ADDR_PART_ID_LOW |=>
            reg_rdata == PART_ID[7:0];
    endproperty
    a_id_low: assert property (p_id_low)
        else $error("id low register read wrong");

    property p_gate_one_write;
        @(posedge clock) disable iff (!rst_n)
        wr_gate_one |=> periph_clock_gate_one_en == $past(reg_wdata);
    endproperty
    a_gate_one_write: assert property (p_gate_one_write)
        else $error("gate one did not take the written value");

    property p_gate_two_write;
        @(posedge clock) disable iff (!rst_n)
        wr_gate_two |=> periph_clock_gate_two_en == $past(reg_wdata) ##1
            ($past(reg_wr) ||
            periph_clock_gate_two_en == $past(reg_wdata, 2));
    endproperty
    a_gate_two_write: assert property (p_gate_two_write)
        else $error("gate two did not take or hold the written value");

    property p_tod_gate;
        @(posedge clock) disable iff (!rst_n)
        time_of_day_bus_en == periph_clock_gate_two_en[2] &&
            time_of_day_count_clk == time_of_day_source_clk;
    endproperty
    a_tod_gate: assert property (p_tod_gate)
        else $error("time of day gating reaches its count clock");

    property p_delay_gate;
        @(posedge clock) disable iff (!rst_n)
        wr_gate_two |=> delay_block_reg_bus_en == $past(reg_wdata[6]);
    endproperty
    a_delay_gate: assert property (p_delay_gate)
        else $error("delay block register clock enable wrong");

    property p_pair_gate;
        @(posedge clock) disable iff (!rst_n)
        keyboard_interrupt_bus_en == {2{periph_clock_gate_two_en[4]}} &&
        programmable_comparator_bus_en == {2{periph_clock_gate_two_en[3]}};
    endproperty
    a_pair_gate: assert property (p_pair_gate)
        else $error("paired module enables split");

    property p_sel_reset;
        @(posedge clock)
        $rose(rst_n) |-> sel_ff == sys_clock_pkg::SEL_OFF &&
            !clock_output_pin;
    endproperty
    a_sel_reset: assert property (p_sel_reset)
        else $error("select not 000 after reset");

    property p_sel_hold;
        @(posedge clock) disable iff (!rst_n)
        !wr_sel |=> $stable(sel_ff) && $stable(first_timer_ext_clk_alt);
    endproperty
    a_sel_hold: assert property (p_sel_hold)
        else $error("select register moved without a write");

    property p_test_bit_write;
        @(posedge clock) disable iff (!rst_n)
        wr_sel |=> first_timer_ext_clk_alt == $past(reg_wdata[7]);
    endproperty
    a_test_bit_write: assert property (p_test_bit_write)
        else $error("timer clock select bit not taken from the write");

    property p_gate_one_hold;
        @(posedge clock) disable iff (!rst_n)
        !wr_gate_one |=> $stable(periph_clock_gate_one_en);
    endproperty
    a_gate_one_hold: assert property (p_gate_one_hold)
        else $error("gate one moved without a write");

    property p_gate_two_hold;
        @(posedge clock) disable iff (!rst_n)
        !wr_gate_two |=> $stable(periph_clock_gate_two_en);
    endproperty
    a_gate_two_hold: assert property (p_gate_two_hold)
        else $error("gate two moved without a write");

endmodule // sys_clock_out_gate_and_id

// File: rtl/sys_clock_consts.svh
// Offsets, field positions, reset values and identity of the clock block
`ifndef SYS_CLOCK_CONSTS_SVH
`define SYS_CLOCK_CONSTS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define ADDR_CLOCK_OUTPUT_SELECT 3'h0
`define ADDR_PART_ID_HIGH 3'h1
`define ADDR_PART_ID_LOW 3'h2
`define ADDR_PERIPH_CLOCK_GATE_ONE 3'h3
`define ADDR_PERIPH_CLOCK_GATE_TWO 3'h4

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define SEL_MSB 2
`define SEL_LSB 0
`define TEST_BIT 7
`define GATE_TWO_DELAY_BIT 6
`define GATE_TWO_KEYBOARD_BIT 4
`define GATE_TWO_COMPARATOR_BIT 3
`define GATE_TWO_TIME_OF_DAY_BIT 2

// ----------------------------------------------------------------------
// Reset values and identity
// ----------------------------------------------------------------------
`define RST_CLOCK_OUTPUT_SELECT 8'h00
`define RST_PERIPH_CLOCK_GATE 8'h00
// Arbitrary identification value
`define PART_ID_VALUE 12'h5a3

`endif

// File: rtl/sys_clock_pkg.sv
// Types shared by the clock output, gating and identification block
package sys_clock_pkg;

    // Encoding order gives 000 low, 001 xtal1 ... 110 low-power clock
    typedef enum logic [2:0] {
        SEL_OFF,
        SEL_XTAL_ONE,
        SEL_XTAL_TWO,
        SEL_RC_OSC,
        SEL_BUS_CLOCK,
        SEL_CPU_CLOCK,
        SEL_LOW_POWER_OSC
    } clk_out_sel_type;

endpackage

// File: rtl/clk_src_if.sv
// Clock sources and select travelling to the output multiplexer
`timescale 1ns/1ps

interface clk_src_if;
    logic xtal_one;
    logic xtal_two;
    logic rc_osc;
    logic bus_clock;
    logic cpu_clock;
    logic low_power_osc_clock;
    sys_clock_pkg::clk_out_sel_type sel;
    logic mux_out;

    modport ctrl (
        output xtal_one, xtal_two, rc_osc, bus_clock, cpu_clock,
        output low_power_osc_clock, sel,
        input mux_out
    );
    modport mux (
        input xtal_one, xtal_two, rc_osc, bus_clock, cpu_clock,
        input low_power_osc_clock, sel,
        output mux_out
    );
endinterface

// File: rtl/clk_out_mux.sv
// Clock output multiplexer
`timescale 1ns/1ps

module clk_out_mux (
    // Sources and select
    clk_src_if.mux src
);

    // Pure selection: a stopped source gives a still output, no gating here
    always_comb begin
        case (src.sel)
            sys_clock_pkg::SEL_XTAL_ONE: src.mux_out = src.xtal_one;
            sys_clock_pkg::SEL_XTAL_TWO: src.mux_out = src.xtal_two;
            sys_clock_pkg::SEL_RC_OSC: src.mux_out = src.rc_osc;
            sys_clock_pkg::SEL_BUS_CLOCK: src.mux_out = src.bus_clock;
            sys_clock_pkg::SEL_CPU_CLOCK: src.mux_out = src.cpu_clock;
            sys_clock_pkg::SEL_LOW_POWER_OSC: begin
                src.mux_out = src.low_power_osc_clock;
            end
            default: src.mux_out = 1'b0;
        endcase
    end

endmodule // clk_out_mux

// File: tb/tb_sys_clock_out_gate_and_id.sv
// Self-checking bench for clock output select, gating and part id block
`timescale 1ns/1ps
`include "sys_clock_consts.svh"

module tb_sys_clock_out_gate_and_id;
    // Arbitrary identification value, differs from the design default
    localparam logic [11:0] ID_VAL = 12'h0c7;
    logic clock;
    logic rst_n;
    logic [2:0] reg_addr;
    logic [7:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [7:0] reg_rdata;
    // Index is select code minus one; bit 3 is unconnected, the bus clock is clock
    logic [5:0] src;
    logic tod_src;
    logic pin;
    logic alt;
    logic [7:0] gate_one;
    logic [7:0] gate_two;
    logic [1:0] kbd_en;
    logic [1:0] cmp_en;
    logic delay_en;
    logic tod_en;
    logic tod_cnt;
    logic [7:0] rd;
    logic [7:0] onehot;
    logic exp_pin;
    int errors;
    int check_count;

    sys_clock_out_gate_and_id #(.PART_ID(ID_VAL)) dut (
        .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .xtal_one_clk(src[0]),
        .xtal_two_clk(src[1]), .rc_osc_clk(src[2]), .cpu_clock(src[4]),
        .low_power_osc_clock(src[5]), .time_of_day_source_clk(tod_src),
        .clock_output_pin(pin), .first_timer_ext_clk_alt(alt),
        .periph_clock_gate_one_en(gate_one),
        .periph_clock_gate_two_en(gate_two),
        .keyboard_interrupt_bus_en(kbd_en),
        .programmable_comparator_bus_en(cmp_en),
        .delay_block_reg_bus_en(delay_en), .time_of_day_bus_en(tod_en),
        .time_of_day_count_clk(tod_cnt)
    );

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic reg_write(input logic [2:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
        #1;
    endtask

    // Data is sampled in the single cycle after the strobe
    task automatic check_reg(input logic [2:0] a, input logic [7:0] exp);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        check(reg_rdata, exp);
    endtask

    task automatic check_two(input logic [7:0] v);
        check(gate_two, v);
        check({6'h00, kbd_en}, {6'h00, {2{v[4]}}});
        check({6'h00, cmp_en}, {6'h00, {2{v[3]}}});
        check({7'h00, delay_en}, {7'h00, v[6]});
        check({7'h00, tod_en}, {7'h00, v[2]});
    endtask

    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Clock and watchdog
    // ------------------------------------------------------------------
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    // The sequence needs well under a thousand cycles
    initial begin
        #(100 * 3000);
        errors++;
        wrap_up();
    end

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        reg_addr = 3'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        src = 6'h3f;
        tod_src = 1'b0;
        errors = 0;
        check_count = 0;
        repeat (8) @(posedge clock);
        rst_n <= 1'b1;
        #1;
        check({7'h00, pin}, 8'h00);
        check_reg(`ADDR_CLOCK_OUTPUT_SELECT, 8'h00);
        check(gate_one, 8'h00);
        check_two(8'h00);
        // Id registers ignore writes and keep the upper nibble at zero
        for (int k = 0; k < 2; k++) begin
            check_reg(`ADDR_PART_ID_HIGH, {4'h0, ID_VAL[11:8]});
            check_reg(`ADDR_PART_ID_LOW, ID_VAL[7:0]);
            reg_write(`ADDR_PART_ID_HIGH, 8'hff);
            reg_write(`ADDR_PART_ID_LOW, 8'h00);
        end
        @(posedge clock);
        #1;
        check(reg_rdata, 8'h00);
        // Gate one, unmapped place does not alias onto it
        reg_write(`ADDR_PERIPH_CLOCK_GATE_ONE, 8'ha5);
        check(gate_one, 8'ha5);
        reg_write(`ADDR_PERIPH_CLOCK_GATE_ONE, 8'h5a);
        reg_write(3'h5, 8'hff);
        check(gate_one, 8'h5a);
        check_reg(`ADDR_PERIPH_CLOCK_GATE_ONE, 8'h5a);
        check_reg(3'h5, 8'h00);
        // Walking one through gate two
        for (int i = 0; i < 8; i++) begin
            reg_write(`ADDR_PERIPH_CLOCK_GATE_TWO, 8'h01 << i);
            check_two(8'h01 << i);
            check_reg(`ADDR_PERIPH_CLOCK_GATE_TWO, 8'h01 << i);
        end
        // Count clock of time-of-day passes whatever its gate bit
        for (int g = 0; g < 2; g++) begin
            reg_write(`ADDR_PERIPH_CLOCK_GATE_TWO, (g == 1) ? 8'h04 : 8'h00);
            @(posedge clock);
            tod_src <= 1'b1;
            #1;
            check({7'h00, tod_cnt}, 8'h01);
            @(posedge clock);
            tod_src <= 1'b0;
            #1;
            check({7'h00, tod_cnt}, 8'h00);
        end
        // Every select code, reserved bits 6:3 written as ones
        for (int c = 0; c < 8; c++) begin
            reg_write(`ADDR_CLOCK_OUTPUT_SELECT, 8'h78 | c[7:0]);
            check_reg(`ADDR_CLOCK_OUTPUT_SELECT, {5'h00, c[2:0]});
            onehot = (c == 0 || c == 7) ? 8'h00 : 8'h01 << (c - 1);
            exp_pin = (c != 0 && c != 7);
            @(posedge clock);
            src <= onehot[5:0];
            #1;
            check({7'h00, pin}, {7'h00, exp_pin});
            @(posedge clock);
            src <= ~onehot[5:0];
            #1;
            check({7'h00, pin}, {7'h00, c == 4});
            if (c == 4) begin
                @(negedge clock);
                #1;
                check({7'h00, pin}, 8'h00);
            end
        end
        // Bit 7 is kept and steers the first timer
        reg_write(`ADDR_CLOCK_OUTPUT_SELECT, 8'h85);
        check({7'h00, alt}, 8'h01);
        check_reg(`ADDR_CLOCK_OUTPUT_SELECT, 8'h85);
        reg_write(`ADDR_CLOCK_OUTPUT_SELECT, 8'h05);
        check({7'h00, alt}, 8'h00);
        // Reset in mid-run clears everything at once
        reg_write(`ADDR_CLOCK_OUTPUT_SELECT, 8'h81);
        reg_write(`ADDR_PERIPH_CLOCK_GATE_ONE, 8'hff);
        reg_write(`ADDR_PERIPH_CLOCK_GATE_TWO, 8'hff);
        @(posedge clock);
        src <= 6'h3f;
        rst_n <= 1'b0;
        #1;
        check({6'h00, pin, alt}, 8'h00);
        check(gate_one, 8'h00);
        check_two(8'h00);
        @(posedge clock);
        rst_n <= 1'b1;
        check_reg(`ADDR_CLOCK_OUTPUT_SELECT, 8'h00);
        wrap_up();
    end
endmodule // tb_sys_clock_out_gate_and_id
